//--- hw/tgs_pkg.sv
package tgs_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_BASE   = 8'h04;
    localparam logic [7:0]  ADDR_STATUS = 8'h08;
    localparam logic [7:0]  ADDR_FETCH  = 8'h0c;
    localparam int          CTRL_SRC    = 0;
    localparam int          CTRL_TALL   = 2;
    localparam int          CTRL_SCR_LO = 4;
    localparam int          CTRL_BPP_LO = 8;
    localparam int          CTRL_FY_LO  = 12;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_7000;
    localparam logic [15:0] BASE_RESET  = 16'h0000;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    localparam logic [7:0]  ROM_COUNT   = 8'ha0;
    localparam logic [7:0]  BLANK_CODE  = 8'h20;

    typedef struct packed {
        logic [3:0] fy_m1;     // glyph lines minus one
        logic [1:0] bpp;       // 0:1bpp 1:2bpp 2:4bpp
        logic [2:0] scroll;
        logic       tall;
        logic       ram_only;
    } tgs_cfg_type;

    typedef struct packed {
        logic        valid;
        logic        from_ram;
        logic [15:0] addr;
        logic [3:0]  row;
        logic [2:0]  shift;
    } tgs_fetch_type;
endpackage

//--- hw/tgs_glyph_fetch.sv
`timescale 1ns/1ps
module tgs_glyph_fetch
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  char_valid,
    input  wire logic [7:0]            char_code,
    input  wire logic                  col_last,
    input  wire logic                  line_end,
    input  wire logic                  row_start,
    output tgs_pkg::tgs_fetch_type     fetch_q,
    output logic                       mono_forced_q
);
    import tgs_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // codes served by the user glyph ram when the rom is present
    function automatic logic is_user_code(input logic [7:0] c);
        is_user_code = (c[7:5] == 3'b100) || (c[7:5] == 3'b111);
    endfunction

    // merge a write into a word under byte enables
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [7:0]  aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] base_q, base_d;
    tgs_cfg_type cfg;
    tgs_fetch_type fetch_d;
    logic [3:0]  row_q, row_d;
    logic        mono_d;
    logic [15:0] last_q, last_d;

    assign cfg = '{fy_m1: ctrl_q[CTRL_FY_LO +: 4], bpp: ctrl_q[CTRL_BPP_LO +: 2],
                   scroll: ctrl_q[CTRL_SCR_LO +: 3], tall: ctrl_q[CTRL_TALL],
                   ram_only: ctrl_q[CTRL_SRC]};

    // address/data capture, register writes and reads
    always_comb
    begin
        logic [31:0] wd;
        wd        = 32'h0;
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        aw_addr_d = aw_addr_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        ctrl_d    = ctrl_q;
        base_d    = base_q;
        if (s_axi_awvalid && !aw_held_q)
        begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_q)
        begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (aw_held_q && w_held_q && !bvalid_q)
        begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            unique case (aw_addr_q)
                ADDR_CTRL:
                begin
                    wd     = merge(ctrl_q, w_data_q, w_strb_q);
                    ctrl_d = {16'h0, wd[15:12], 2'b00, wd[9:8], 1'b0, wd[6:4],
                              1'b0, wd[2], 1'b0, wd[0]};
                end
                ADDR_BASE:
                begin
                    wd     = merge({16'h0, base_q}, w_data_q, w_strb_q);
                    base_d = wd[15:0];
                end
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_CTRL:   rdata_d = ctrl_q;
                ADDR_BASE:   rdata_d = {16'h0, base_q};
                ADDR_STATUS: rdata_d = {26'h0, mono_forced_q, fetch_q.from_ram, row_q};
                ADDR_FETCH:  rdata_d = {16'h0, last_q};
                default:
                begin
                    rdata_d = 32'h0;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
        // awready and wready registered as the inverse of the held flags, arready as the inverse of rvalid
        awready_d = !aw_held_d;
        wready_d  = !w_held_d;
        arready_d = !rvalid_d;
    end

    // bus registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            arready_q <= 1'b1;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h0;
            ctrl_q    <= CTRL_RESET;
            base_q    <= BASE_RESET;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            aw_addr_q <= aw_addr_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            ctrl_q    <= ctrl_d;
            base_q    <= base_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // ------------------------------------------------------------
    // glyph row select and fetch address
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0]  code;
        logic        use_ram;
        logic [15:0] code_off;
        logic [15:0] row_off;
        code     = char_code;
        use_ram  = 1'b0;
        code_off = 16'h0;
        row_off  = 16'h0;
        fetch_d  = fetch_q;
        row_d    = row_q;
        // row restarts at each text row, advances once per scan line
        if (row_start)
        begin
            row_d = 4'h0;
        end
        else if (line_end)
        begin
            row_d = (row_q >= cfg.fy_m1) ? 4'h0 : row_q + 4'h1;
        end
        // scrolled row end without an enlarged row shows blank
        if (col_last && cfg.scroll != 3'h0)
        begin
            code = BLANK_CODE;
        end
        use_ram = cfg.ram_only || is_user_code(code);
        if (cfg.tall)
        begin
            code_off = {4'h0, code, 4'h0};
            row_off  = {12'h0, row_q};
        end
        else
        begin
            code_off = {5'h0, code, 3'h0};
            row_off  = {13'h0, row_q[2:0]};
        end
        fetch_d.valid    = char_valid;
        fetch_d.from_ram = use_ram;
        // user glyph ram may sit anywhere; rom codes fetch by code alone
        fetch_d.addr     = use_ram ? base_q + code_off + row_off
                                   : {8'h0, code};
        fetch_d.row      = row_q;
        // one scroll offset shared by every text block
        fetch_d.shift    = cfg.scroll;
        mono_d           = use_ram || cfg.ram_only;
        // fetch address register keeps the address of the last real byte
        last_d           = char_valid ? fetch_d.addr : last_q;
    end

    // fetch registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fetch_q       <= '0;
            row_q         <= 4'h0;
            mono_forced_q <= 1'b0;
            last_q        <= 16'h0000;
        end
        else
        begin
            fetch_q       <= fetch_d;
            row_q         <= row_d;
            mono_forced_q <= mono_d;
            last_q        <= last_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_row_restart;
        @(posedge aclk) disable iff (!aresetn) row_start |=> row_q == 4'h0;
    endproperty
    a_row_restart: assert property (p_row_restart) else $error("row not restarted");

    property p_blank_end;
        @(posedge aclk) disable iff (!aresetn)
        (col_last && cfg.scroll != 3'h0 && !cfg.ram_only && !cfg.tall)
        |=> fetch_q.addr == {8'h0, BLANK_CODE};
    endproperty
    a_blank_end: assert property (p_blank_end) else $error("no blank at end");

    property p_user_range;
        @(posedge aclk) disable iff (!aresetn)
        (char_valid && !col_last && !cfg.ram_only && char_code[7:5] == 3'b100)
        |=> fetch_q.from_ram;
    endproperty
    a_user_range: assert property (p_user_range) else $error("user code missed");

    property p_rom_range;
        @(posedge aclk) disable iff (!aresetn)
        (!col_last && !cfg.ram_only && char_code < 8'h80) |=> !fetch_q.from_ram;
    endproperty
    a_rom_range: assert property (p_rom_range) else $error("rom code to ram");

    property p_short_addr;
        @(posedge aclk) disable iff (!aresetn)
        (!col_last && !cfg.tall && cfg.ram_only && ctrl_d == ctrl_q && base_d == base_q)
        |=> fetch_q.addr == base_q + {5'h0, $past(char_code), 3'h0} + {13'h0, $past(row_q[2:0])};
    endproperty
    a_short_addr: assert property (p_short_addr) else $error("short address wrong");

    property p_tall_addr;
        @(posedge aclk) disable iff (!aresetn)
        (!col_last && cfg.tall && cfg.ram_only && ctrl_d == ctrl_q && base_d == base_q)
        |=> fetch_q.addr == base_q + {4'h0, $past(char_code), 4'h0} + {12'h0, $past(row_q)};
    endproperty
    a_tall_addr: assert property (p_tall_addr) else $error("tall address wrong");

    property p_shift;
        @(posedge aclk) disable iff (!aresetn) ##1 fetch_q.shift == $past(cfg.scroll);
    endproperty
    a_shift: assert property (p_shift) else $error("shift mismatch");

    property p_mono;
        @(posedge aclk) disable iff (!aresetn) cfg.ram_only |=> mono_forced_q;
    endproperty
    a_mono: assert property (p_mono) else $error("mono not forced");
endmodule

//--- testbench/tgs_scan_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// character byte source standing in for display memory scan
// ------------------------------------------------------------
module tgs_scan_model
(
    input  wire logic        aclk,
    input  wire logic        go,
    input  wire logic        first,
    input  wire logic [31:0] codes,
    output logic             char_valid = 1'b0,
    output logic [7:0]       char_code  = 8'h00,
    output logic             col_last   = 1'b0,
    output logic             line_end   = 1'b0,
    output logic             row_start  = 1'b0,
    output logic             busy       = 1'b0
);
    int k = 0;
    // one scan line: optional row start, four bytes, then line end
    always @(posedge aclk)
    begin
        row_start  <= 1'b0;
        line_end   <= 1'b0;
        char_valid <= 1'b0;
        col_last   <= 1'b0;
        char_code  <= ~char_code; // released bus must not look valid
        if (go && k == 0)
        begin
            busy      <= 1'b1;
            row_start <= first;
            k         <= 1;
        end
        else if (k >= 1 && k <= 4)
        begin
            char_valid <= 1'b1;
            char_code  <= codes[8*(k-1)+:8]; // same bytes each line
            col_last   <= (k == 4); // four-wide row, bytes-per-row not enlarged
            k          <= k + 1;
        end
        else if (k == 5)
        begin
            line_end <= 1'b1;
            busy     <= 1'b0;
            k        <= 0;
        end
    end
endmodule

//--- testbench/text_glyph_address_scroll_tb_top.sv
`timescale 1ns/1ps
module text_glyph_address_scroll_tb_top;
    import tgs_pkg::*;
    logic aclk = 0, aresetn = 0, go = 0, first = 0, ro = 0, tall = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pc = 0;
    logic [31:0] s_axi_wdata = 0, codes = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, pv = 0, pl = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic char_valid, col_last, line_end, row_start, busy, mono_forced_q;
    logic [7:0] char_code;
    logic [3:0] row_m = 0, pr = 0, fy = 4'h7;
    logic [2:0] scr = 0;
    logic [15:0] base = 0;
    tgs_fetch_type fetch_q;
    int fail_count = 0, checks_done = 0;
    tgs_glyph_fetch uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .char_valid(char_valid), .char_code(char_code),
        .col_last(col_last), .line_end(line_end), .row_start(row_start),
        .fetch_q(fetch_q), .mono_forced_q(mono_forced_q));
    tgs_scan_model scan (.aclk(aclk), .go(go), .first(first), .codes(codes),
        .char_valid(char_valid), .char_code(char_code), .col_last(col_last),
        .line_end(line_end), .row_start(row_start), .busy(busy));
    // 125 MHz clock
    initial forever #4 aclk = ~aclk;
    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic tmo;
        fail_count++;
        end_sim;
    endtask
    // expected fetch worked out from the mode mirrors
    function automatic tgs_fetch_type exp_f(input logic [7:0] c, input logic l,
                                            input logic [3:0] r);
        tgs_fetch_type f;
        if (l && scr != 3'd0) c = BLANK_CODE;
        f.valid    = 1'b1;
        f.row      = r;
        f.shift    = scr;
        f.from_ram = ro || (c >= 8'h80 && c <= 8'h9f) || c >= 8'he0;
        if (!f.from_ram) f.addr = {8'h00, c};
        else if (tall) f.addr = base + {4'h0, c, 4'h0} + {12'h000, r};
        else f.addr = base + {5'h00, c, 3'h0} + {13'h0000, r[2:0]};
        return f;
    endfunction
    // row mirror and capture of what the design sampled
    always @(posedge aclk)
    begin
        pv <= char_valid;
        pc <= char_code;
        pl <= col_last;
        pr <= row_m;
        if (!aresetn || row_start) row_m <= 4'h0;
        else if (line_end) row_m <= (row_m >= fy) ? 4'h0 : row_m + 4'h1;
    end
    // compare the registered fetch one cycle after its byte
    always @(negedge aclk)
        if (aresetn && pv) chk("fetch", {7'h0, fetch_q}, {7'h0, exp_f(pc, pl, pr)});
        else if (aresetn) chk("fetch_valid", {31'h0, fetch_q.valid}, 32'h0);
    // ------------------------------------------------------------
    // bus and scan drivers
    // ------------------------------------------------------------
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 64) tmo;
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                chk("rdata", s_axi_rdata, e);
                chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 64) tmo;
    endtask
    // mode write with readback; bpp kept at 1bpp so any scroll is legal
    task automatic set_cfg(input logic o, input logic t, input logic [2:0] s,
                           input logic [3:0] f, input logic [15:0] b);
        logic [31:0] d;
        d = {16'h0000, f, 4'h0, 1'b0, s, 1'b0, t, 1'b0, o};
        axw(ADDR_CTRL, d, RESP_OKAY);
        axr(ADDR_CTRL, d, RESP_OKAY);
        axw(ADDR_BASE, {16'h0000, b}, RESP_OKAY);
        {ro, tall, scr, fy, base} = {o, t, s, f, b};
    endtask
    task automatic line(input logic f, input logic [31:0] c);
        int n;
        @(posedge aclk);
        go    <= 1'b1;
        first <= f;
        codes <= c;
        @(posedge aclk);
        go <= 1'b0;
        // let busy rise before waiting for it to fall
        @(posedge aclk);
        for (n = 0; n < 64 && busy !== 1'b0; n++) @(posedge aclk);
        if (n == 64) tmo;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("fetch_rst", {7'h0, fetch_q}, 32'h0);
        axr(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
        axr(ADDR_BASE, 32'h0, RESP_OKAY);
        axw(8'h10, 32'hffff_ffff, RESP_SLVERR);
        axr(8'h10, 32'h0, RESP_SLVERR);
        s_axi_wstrb <= 4'h1;
        axw(ADDR_BASE, 32'h0000_5a5a, RESP_OKAY); // low byte lane only
        s_axi_wstrb <= 4'hf;
        axr(ADDR_BASE, 32'h0000_005a, RESP_OKAY);
        axr(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
    endtask
    // code range edges, short glyphs, three-line rows wrapping
    task automatic t_ranges;
        int i;
        set_cfg(1'b0, 1'b0, 3'd0, 4'd2, 16'h4800);
        for (i = 0; i < 4; i++) line(i == 0, i[0] ? 32'he0ffdf00 : 32'h7fa09f80);
        axr(ADDR_FETCH, {16'h0, exp_f(8'he0, 1'b1, 4'd0).addr}, RESP_OKAY);
    endtask
    // sixteen-line glyphs, full row select sweep and wrap
    task automatic t_tall;
        int i;
        set_cfg(1'b0, 1'b1, 3'd0, 4'd15, 16'h1234);
        for (i = 0; i < 17; i++) line(i == 0, 32'h9ffe4181);
    endtask
    // every pixel scroll value, blank substituted at row end
    task automatic t_scroll;
        int s;
        for (s = 0; s < 8; s++)
        begin
            set_cfg(1'b0, 1'b0, s[2:0], 4'd7, 16'h0100);
            line(1'b1, 32'h85e12230);
        end
    endtask
    // every code from user glyph ram, one bit per pixel forced
    task automatic t_ramonly;
        set_cfg(1'b1, 1'b0, 3'd0, 4'd7, 16'h0000);
        line(1'b1, 32'h207f4100);
        chk("mono", {31'h0, mono_forced_q}, 32'h1);
        axr(ADDR_STATUS, 32'h0000_0031, RESP_OKAY);
    endtask
    // reset then run the scenarios
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_ranges;
        t_tall;
        t_scroll;
        t_ramonly;
        end_sim;
    end
endmodule
